// ### port_io_pkg.sv
/*
  Package for the port I/O configuration and edge-flag block: register
  addresses, reset values, bit positions and the carrier structs.
  Assumes an 8-bit SFR-style register port driven by the CPU core.
*/
package port_io_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
  localparam logic [7:0] ADDR_PORT1_DRIVE_MODE = 8'hA5;
  localparam logic [7:0] ADDR_PORT2_DRIVE_MODE = 8'hA6;
  localparam logic [7:0] ADDR_PORT3_DRIVE_MODE = 8'hA7;
  localparam logic [7:0] ADDR_PORT1_EDGE_FLAGS = 8'hAD;
  localparam logic [7:0] ADDR_PORT3_LATCH = 8'hB0;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PORT_LATCH = 8'hFF;
  localparam logic [7:0] RST_DRIVE_MODE = 8'h00;
  localparam logic [3:0] RST_EDGE_FLAGS = 4'h0;
  localparam int EDGE_FLAG_LSB = 4;
  localparam int EDGE_FLAG_MSB = 7;
  localparam logic [3:0] EDGE_UNUSED_READ = 4'h0;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_s;

endpackage : port_io_pkg

// ### port_pin_driver.sv
/*
  One byte-wide output stage: turns a latch and drive-mode byte into
  pin output value and enable.  Assumes the pad resolves open-drain
  release with an external or weak pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
module port_pin_driver
  import port_io_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] push_pull,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe
);

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  // Low is always driven; high only in push-pull, else released
  assign pin_out = latch;
  assign pin_oe = ~latch | push_pull;

endmodule : port_pin_driver
`default_nettype wire

// ### edge_flag_detect.sv
/*
  Falling-edge detector with sticky pending flags.  Assumes the pin
  inputs are already synchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_flag_detect
  import port_io_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] flags_q
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] fall;
  logic [WIDTH-1:0] flags_d;

  // ----------------------------------------------------------------
  // Previous sample, reset high so a pin low at reset counts as an edge
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= '1;
    end else begin
      prev_q <= pin_in;
    end
  end

  assign fall = prev_q & ~pin_in;

  // Software may clear or set; a new edge wins over a clear
  always_comb begin
    flags_d = flags_q;
    if (wr_en) begin
      flags_d = wr_data;
    end
    flags_d = flags_d | fall;
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= RST_EDGE_FLAGS;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : edge_flag_detect
`default_nettype wire

// ### port_io_config.sv
/*
  Port I/O drive configuration, port 2/3 latches with pin readback and
  port 1 falling-edge flags.  Assumes an SFR-style port: one-cycle write
  and read strobes with an 8-bit address, read data one cycle later.
  Crossbar routing lives outside; port 2 takes a per-pin override.
*/
`timescale 1ns/1ps
`default_nettype none
module port_io_config
  import port_io_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire reg_req_s req,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port2_pin_in,
  input wire logic [7:0] port3_pin_in,
  input wire pin_drive_s port2_xbar_drive,
  input wire logic [7:0] port2_xbar_sel,
  input wire logic [7:0] port1_xbar_out,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic [7:0] port1_pin_out_q,
  output logic [7:0] port1_pin_oe_q,
  output logic [7:0] port2_pin_out_q,
  output logic [7:0] port2_pin_oe_q,
  output logic [7:0] port3_pin_out_q,
  output logic [7:0] port3_pin_oe_q
);

  logic [7:0] port2_latch_q;
  logic [7:0] port3_latch_q;
  logic [7:0] port1_drive_mode_q;
  logic [7:0] port2_drive_mode_q;
  logic [7:0] port3_drive_mode_q;
  logic [3:0] edge_flags;
  logic edge_wr;
  logic [7:0] rdata_d;
  pin_drive_s p1_drv;
  pin_drive_s p2_drv;
  pin_drive_s p3_drv;
  pin_drive_s p2_mux;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Drive-mode registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port1_drive_mode_q <= RST_DRIVE_MODE;
      port2_drive_mode_q <= RST_DRIVE_MODE;
      port3_drive_mode_q <= RST_DRIVE_MODE;
    end else if (req.wr) begin
      case (req.addr)
        ADDR_PORT1_DRIVE_MODE: port1_drive_mode_q <= req.wdata;
        ADDR_PORT2_DRIVE_MODE: port2_drive_mode_q <= req.wdata;
        ADDR_PORT3_DRIVE_MODE: port3_drive_mode_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // Data latches; the core supplies the modified latch value on RMW
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port2_latch_q <= RST_PORT_LATCH;
      port3_latch_q <= RST_PORT_LATCH;
    end else if (req.wr) begin
      case (req.addr)
        ADDR_PORT2_LATCH: port2_latch_q <= req.wdata;
        ADDR_PORT3_LATCH: port3_latch_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Edge flags on port 1 upper nibble
  // ----------------------------------------------------------------
  // Low nibble of the write is dropped: those bits do not exist
  assign edge_wr = req.wr && (req.addr == ADDR_PORT1_EDGE_FLAGS);

  edge_flag_detect #(
    .WIDTH(4)
  ) u_edge (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(port1_pin_in[EDGE_FLAG_MSB:EDGE_FLAG_LSB]),
    .wr_en(edge_wr),
    .wr_data(req.wdata[EDGE_FLAG_MSB:EDGE_FLAG_LSB]),
    .flags_q(edge_flags)
  );

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Plain reads see the pins; RMW reads see the latch
  always_comb begin
    rdata_d = UNMAPPED_READ;
    case (req.addr)
      ADDR_PORT2_LATCH: rdata_d = req.rmw ? port2_latch_q : port2_pin_in;
      ADDR_PORT3_LATCH: rdata_d = req.rmw ? port3_latch_q : port3_pin_in;
      ADDR_PORT1_DRIVE_MODE: rdata_d = port1_drive_mode_q;
      ADDR_PORT2_DRIVE_MODE: rdata_d = port2_drive_mode_q;
      ADDR_PORT3_DRIVE_MODE: rdata_d = port3_drive_mode_q;
      ADDR_PORT1_EDGE_FLAGS: rdata_d = {edge_flags, EDGE_UNUSED_READ};
      default: rdata_d = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= UNMAPPED_READ;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stages
  // ----------------------------------------------------------------
  // Port 1 data comes from outside (crossbar / port 1 latch)
  port_pin_driver #(
    .WIDTH(8)
  ) u_drv1 (
    .latch(port1_xbar_out),
    .push_pull(port1_drive_mode_q),
    .pin_out(p1_drv.out),
    .pin_oe(p1_drv.oe)
  );

  port_pin_driver #(
    .WIDTH(8)
  ) u_drv2 (
    .latch(port2_latch_q),
    .push_pull(port2_drive_mode_q),
    .pin_out(p2_drv.out),
    .pin_oe(p2_drv.oe)
  );

  port_pin_driver #(
    .WIDTH(8)
  ) u_drv3 (
    .latch(port3_latch_q),
    .push_pull(port3_drive_mode_q),
    .pin_out(p3_drv.out),
    .pin_oe(p3_drv.oe)
  );

  // Crossbar takes pins it claims; the latch shows elsewhere
  assign p2_mux.out = (port2_xbar_sel & port2_xbar_drive.out) | (~port2_xbar_sel & p2_drv.out);
  assign p2_mux.oe = (port2_xbar_sel & port2_xbar_drive.oe) | (~port2_xbar_sel & p2_drv.oe);

  // Registered pads: one cycle after the register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port1_pin_out_q <= RST_PORT_LATCH;
      port1_pin_oe_q <= 8'h00;
      port2_pin_out_q <= RST_PORT_LATCH;
      port2_pin_oe_q <= 8'h00;
      port3_pin_out_q <= RST_PORT_LATCH;
      port3_pin_oe_q <= 8'h00;
    end else begin
      port1_pin_out_q <= p1_drv.out;
      port1_pin_oe_q <= p1_drv.oe;
      port2_pin_out_q <= p2_mux.out;
      port2_pin_oe_q <= p2_mux.oe;
      port3_pin_out_q <= p3_drv.out;
      port3_pin_oe_q <= p3_drv.oe;
    end
  end

endmodule : port_io_config
`default_nettype wire

// ### port_io_props.sv
/* Checker for port_io_config: read timing, pin readback, edge flags, drive form.
   Assumes binding to the top module, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module port_io_props
  import port_io_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire reg_req_s req,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port3_pin_in,
  input wire logic [7:0] rdata_q,
  input wire logic rvalid_q,
  input wire logic [7:0] port1_pin_out_q,
  input wire logic [7:0] port1_pin_oe_q,
  input wire logic [7:0] port3_pin_out_q,
  input wire logic [7:0] port3_pin_oe_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Edge on pin 7, then a flag read
  sequence s_fall7;
    port1_pin_in[7] ##1 !port1_pin_in[7];
  endsequence
  sequence s_rd_flags;
    req.rd && req.addr == ADDR_PORT1_EDGE_FLAGS;
  endsequence
  a_rvalid_follows: assert property (req.rd |=> rvalid_q) else $error("rvalid late");
  a_rvalid_cause: assert property (rvalid_q |-> $past(req.rd)) else $error("rvalid stray");
  a_p3_read_pins: assert property (req.rd && !req.rmw && req.addr == ADDR_PORT3_LATCH
    |=> rdata_q == $past(port3_pin_in)) else $error("p3 read");
  a_flags_low_zero: assert property (rvalid_q && $past(req.addr) == ADDR_PORT1_EDGE_FLAGS
    |-> rdata_q[3:0] == EDGE_UNUSED_READ) else $error("low flags");
  // Flag read soon after a fall must show it
  // Read right after the fall, so no legal clear can slip in between
  a_edge_sets_flag: assert property (s_fall7 ##1 s_rd_flags |=> rdata_q[7]) else $error("flag7");
  // A low output on ports 1 and 3 is always driven
  a_p3_low_driven: assert property ((port3_pin_oe_q | port3_pin_out_q) == 8'hFF) else $error("p3 oe");
  a_p1_low_driven: assert property ((port1_pin_oe_q | port1_pin_out_q) == 8'hFF) else $error("p1 oe");
  a_p3_mode_write: assert property (req.wr && req.addr == ADDR_PORT3_DRIVE_MODE |-> ##2
    (port3_pin_oe_q & port3_pin_out_q) == ($past(req.wdata, 2) & port3_pin_out_q)) else $error("p3 mode");
endmodule : port_io_props
`default_nettype wire

// ### pin_load.sv
/* Pin load: pad level from drive value and enable.
   Assumes a pull-up on each pin and a switch to ground. */
`timescale 1ns/1ps
`default_nettype none
module pin_load (
  input wire logic [7:0] out,
  input wire logic [7:0] oe,
  input wire logic [7:0] pull_low,
  output logic [7:0] level
);
  // Released pins float high; the ground switch beats a driven high
  assign level = (out | ~oe) & ~pull_low;
endmodule : pin_load
`default_nettype wire

// ### testbench.sv
/* Testbench for port_io_config: register reads and writes, pins, edge flags.
   Assumes pin_load models the pads of all three ports. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_io_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  reg_req_s req = '0;
  pin_drive_s xdrv = '0;
  logic [7:0] xsel = 8'h00;
  logic [7:0] xout = 8'hFF;
  logic [7:0] pl1 = 8'h00, pl3 = 8'h00;
  logic [7:0] lv1, lv2, lv3, rdata_q, o1, e1, o2, e2, o3, e3;
  logic rvalid_q;
  int n_fail = 0;
  int num_checks = 0;
  port_io_config DUT (.mclk(mclk), .rst_n(rst_n), .req(req), .port1_pin_in(lv1), .port2_pin_in(lv2),
    .port3_pin_in(lv3), .port2_xbar_drive(xdrv), .port2_xbar_sel(xsel), .port1_xbar_out(xout),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .port1_pin_out_q(o1), .port1_pin_oe_q(e1),
    .port2_pin_out_q(o2), .port2_pin_oe_q(e2), .port3_pin_out_q(o3), .port3_pin_oe_q(e3));
  pin_load pads1 (.out(o1), .oe(e1), .pull_low(pl1), .level(lv1));
  pin_load pads2 (.out(o2), .oe(e2), .pull_low(8'h00), .level(lv2));
  pin_load pads3 (.out(o3), .oe(e3), .pull_low(pl3), .level(lv3));
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) req <= '{wr: 1'b1, rd: 1'b0, rmw: 1'b0, addr: a, wdata: d};
    @(posedge mclk) req.wr <= 1'b0;
  endtask : wr
  // Read strobe; data and valid land one cycle later
  task automatic rd(input logic [7:0] a, input logic m, input logic [7:0] exp);
    @(posedge mclk) req <= '{wr: 1'b0, rd: 1'b1, rmw: m, addr: a, wdata: 8'h00};
    @(posedge mclk) req.rd <= 1'b0;
    #1 chk({7'h00, rvalid_q}, 8'h01);
    chk(rdata_q, exp);
  endtask : rd
  task automatic end_sim;
    if (n_fail == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    forever #5 mclk = ~mclk;
  end
  // Whole run is about 62 cycles
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    #1 chk(e3, ~RST_PORT_LATCH | RST_DRIVE_MODE);
    chk(o3, RST_PORT_LATCH);
    rd(ADDR_PORT2_LATCH, 1'b1, RST_PORT_LATCH);
    rd(ADDR_PORT3_DRIVE_MODE, 1'b0, RST_DRIVE_MODE);
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'h00);
    // Port 3: pin 6 released and pulled low outside
    pl3 <= 8'h40;
    wr(ADDR_PORT3_LATCH, 8'h5A);
    wr(ADDR_PORT3_DRIVE_MODE, 8'h0F);
    repeat (2) @(posedge mclk);
    #1 chk(e3, 8'hAF);
    chk(o3, 8'h5A);
    rd(ADDR_PORT3_LATCH, 1'b0, 8'h1A);
    rd(ADDR_PORT3_LATCH, 1'b1, 8'h5A);
    // Port 2 with crossbar owning pin 0
    xsel <= 8'h01;
    xdrv <= '{out: 8'h01, oe: 8'h01};
    wr(ADDR_PORT2_LATCH, 8'h3C);
    wr(ADDR_PORT2_DRIVE_MODE, 8'hF0);
    repeat (2) @(posedge mclk);
    #1 chk(e2, 8'hF3);
    chk(o2, 8'h3D);
    rd(ADDR_PORT2_LATCH, 1'b0, 8'h3D);
    rd(ADDR_PORT2_LATCH, 1'b1, 8'h3C);
    // Port 1: upper pins stay released high
    xout <= 8'hF0;
    wr(ADDR_PORT1_DRIVE_MODE, 8'h0F);
    repeat (2) @(posedge mclk);
    #1 chk(e1, 8'h0F);
    chk(o1, 8'hF0);
    // Falls on pins 7 and 5, sticky, then cleared and set again
    @(posedge mclk) pl1 <= 8'hA0;
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'hA0);
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'hA0);
    wr(ADDR_PORT1_EDGE_FLAGS, 8'h0F);
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'h00);
    @(posedge mclk) pl1 <= 8'h00;
    @(posedge mclk) pl1 <= 8'h20;
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'h20);
    // Clear and a new fall on pin 5 at one edge: the set wins
    @(posedge mclk) pl1 <= 8'h00;
    fork
      wr(ADDR_PORT1_EDGE_FLAGS, 8'h00);
      begin
        @(posedge mclk) pl1 <= 8'h20;
      end
    join
    rd(ADDR_PORT1_EDGE_FLAGS, 1'b0, 8'h20);
    rd(8'hC0, 1'b0, UNMAPPED_READ);
    end_sim();
  end
endmodule : testbench
bind port_io_config port_io_props u_props (.mclk(mclk), .rst_n(rst_n), .req(req), .port1_pin_in(port1_pin_in),
  .port3_pin_in(port3_pin_in), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .port1_pin_out_q(port1_pin_out_q),
  .port1_pin_oe_q(port1_pin_oe_q), .port3_pin_out_q(port3_pin_out_q), .port3_pin_oe_q(port3_pin_oe_q));
`default_nettype wire
